//--- rsf_pkg.sv
// Package: register map, field positions and codes for the rx status flags
package rsf_pkg;
   localparam logic [11:0] RSF_OFF_MAIN_A = 12'h000;
   localparam logic [11:0] RSF_OFF_MAIN_B = 12'h004;
   localparam logic [11:0] RSF_OFF_COND_A = 12'h008;
   localparam logic [11:0] RSF_OFF_COND_B = 12'h00c;
   localparam logic [11:0] RSF_OFF_CMD = 12'h010;
   localparam logic [11:0] RSF_OFF_CFG_A = 12'h014;
   localparam logic [11:0] RSF_OFF_CFG_B = 12'h018;
   localparam logic [11:0] RSF_OFF_BUS = 12'h01c;
   localparam logic [11:0] RSF_OFF_DATA_A = 12'h020;
   localparam logic [11:0] RSF_OFF_DATA_B = 12'h024;
   // Main status fields
   localparam int RSF_MS_IPEND = 1;
   localparam int RSF_MS_RXAV = 0;
   // Condition status fields
   localparam int RSF_CS_EOF = 7;
   localparam int RSF_CS_CRCFE = 6;
   localparam int RSF_CS_OVR = 5;
   localparam int RSF_CS_PAR = 4;
   localparam int RSF_CS_RES_HI = 3;
   localparam int RSF_CS_RES_LO = 1;
   localparam int RSF_CS_ALLSENT = 0;
   // Command register: bit0 error reset ch A, bit1 ch B
   localparam int RSF_CMD_ERR_A = 0;
   localparam int RSF_CMD_ERR_B = 1;
   // Config: [1:0] mode, [2] parity enable, [3] even, [5:4] rx int mode
   localparam int RSF_CFG_PAREN = 2;
   localparam int RSF_CFG_PAREVEN = 3;
   localparam int RSF_CFG_IM_HI = 5;
   localparam int RSF_CFG_IM_LO = 4;
   localparam logic [1:0] RSF_IM_PAR_SPECIAL = 2'b10;
   localparam logic [1:0] RSF_DMA_NONE = 2'b11;
   localparam logic [2:0] RSF_RES_NONE = 3'h0;
   localparam logic [7:0] RSF_CFG_RST = 8'h00;
   localparam logic [1:0] RSF_BUS_RST = 2'b00;
   localparam int RSF_BUF_DEPTH = 3;
   typedef enum logic [1:0] {RSF_ASYNC, RSF_SYNC, RSF_HDLC} rsf_mode_t;
   // Per-character receive event from the channel's receiver
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic stop_bit;
      logic crc_ok;
      logic closing_flag;
      logic [2:0] residue;
   } rsf_rx_ev_t;
   // Buffer entry: data plus status captured with the character
   typedef struct packed {
      logic [7:0] data;
      logic crc_err;
      logic [2:0] residue;
   } rsf_entry_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pslverr;
   } rsf_apb_rsp_t;
endpackage

//--- rsf_rx_buf.sv
// Three-entry receive buffer with registered read data
`timescale 1ns/100ps
module rsf_rx_buf
   import rsf_pkg::*;
#(
   parameter int DEPTH = RSF_BUF_DEPTH
)
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic wr_i,
   input rsf_entry_t wr_data_i,
   input wire logic rd_i,
   output rsf_entry_t rd_data_o,
   output logic full_o,
   output logic empty_o
);
   // The four-bit fill count would serve up to 15 entries; depth is limited to 8
   if (DEPTH < 2 || DEPTH > 8)
   begin : g_depth_bad
      $error("rsf_rx_buf: DEPTH must be 2..8");
   end

   typedef struct packed {
      rsf_entry_t [DEPTH-1:0] mem;
      logic [3:0] cnt;
      rsf_entry_t rdat;
   } rsf_buf_st_t;

   rsf_buf_st_t s_q;
   rsf_buf_st_t s_d;
   logic do_wr;
   logic do_rd;

   always_comb
   begin
      s_d = s_q;
      do_rd = rd_i && (s_q.cnt != 4'h0);
      do_wr = wr_i && (!full_o || do_rd);
      if (do_rd)
      begin
         s_d.rdat = s_q.mem[0];
         for (int i = 0; i < DEPTH - 1; i++)
            s_d.mem[i] = s_q.mem[i+1];
      end
      if (do_wr)
         s_d.mem[do_rd ? s_q.cnt - 4'h1 : s_q.cnt] = wr_data_i;
      s_d.cnt = s_q.cnt + {3'h0, do_wr} - {3'h0, do_rd};
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign full_o = (s_q.cnt == 4'(DEPTH));
   assign empty_o = (s_q.cnt == 4'h0);
   assign rd_data_o = s_q.rdat;
endmodule // rsf_rx_buf

//--- rsf_status.sv
// Receive status flags and main status for both channels, APB slave
`timescale 1ns/100ps
// Contract
// (RULE1) Pending-interrupt bit exists only in channel A main status; B reads 0.
// (RULE2) Pending bit is 1 while any in-service latch is set.
// (RULE3) With no DMA on either channel, priority input high forces pending 0.
// (RULE4) Character-available is 1 whenever the receive buffer holds a byte.
// (RULE5) Condition status: EOF7, CRC/frame6, overrun5, parity4, residue3:1, sent0.
// (RULE6) HDLC closing flag sets EOF, raises special interrupt, held till reset.
// (RULE7) CRC flag and residue stay stable while EOF is set.
// (RULE8) Async zero stop bit sets framing error and special interrupt.
// (RULE9) Framing error clears on a later good character or error reset.
// (RULE10) Next start bit only after a falling line edge, from character length.
// (RULE11) Sync/HDLC CRC flag shows compare result; cleared by reset commands.
// (RULE12) Sync/HDLC CRC mismatch alone raises no special interrupt.
// (RULE13) CRC result evaluated per character and stored with buffer entry.
// (RULE14) Host should read CRC flag after EOF or twenty bit times.
// (RULE15) Write to full buffer sets overrun, special interrupt, latched.
// (RULE16) Parity mismatch with parity enabled sets latched parity error.
// (RULE17) Parity error raises special interrupt only in receive int mode 2.
// (RULE18) HDLC end of frame reports 3-bit residue with that character.
// (RULE19) Residue codes ordered 100,010,110,001,101,011; 000 means none.
// (RULE20) Async all-sent set when transmit buffer and shifter empty; no irq.
// (RULE21) One error reset clears EOF, CRC, overrun and parity together.
module rsf_status
   import rsf_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input rsf_rx_ev_t rx_ev_a_i,
   input rsf_rx_ev_t rx_ev_b_i,
   input wire logic [1:0] in_service_i,
   input wire logic prio_in_i,
   input wire logic [1:0] tx_empty_i,
   output logic [1:0] special_irq_o
);
   typedef struct packed {
      logic eof;
      logic crcfe;
      logic ovr;
      logic par;
      logic [2:0] res;
   } rsf_flags_t;

   typedef struct packed {
      rsf_flags_t [1:0] fl;
      logic [1:0][7:0] cfg;
      logic [1:0] dma;
      logic [1:0] irq;
      logic [2:0] prio_sync;
      logic prio;
      rsf_apb_rsp_t rsp;
   } rsf_st_t;

   rsf_st_t s_q;
   rsf_st_t s_d;
   rsf_rx_ev_t ev [2];
   rsf_entry_t rd_ent [2];
   logic [1:0] buf_full;
   logic [1:0] buf_empty;
   logic [1:0] buf_rd;
   logic [1:0] err_rst;
   logic apb_wr;
   logic apb_rd;
   rsf_apb_rsp_t rsp_d;

   assign ev[0] = rx_ev_a_i;
   assign ev[1] = rx_ev_b_i;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && penable && !pwrite;
   assign err_rst[0] = apb_wr && paddr == RSF_OFF_CMD && pwdata[RSF_CMD_ERR_A];
   assign err_rst[1] = apb_wr && paddr == RSF_OFF_CMD && pwdata[RSF_CMD_ERR_B];

   // Odd parity over the eight data bits alone is good in odd mode
   function automatic logic par_bad(input logic [7:0] d, input logic even);
      par_bad = even ? ^d : ~^d;
   endfunction

   // Mode field of a channel configuration byte
   function automatic rsf_mode_t mode_of(input logic [7:0] c);
      mode_of = rsf_mode_t'(c[1:0]);
   endfunction

   // Reading a data offset pops the buffer of that channel
   always_comb
   begin
      buf_rd[0] = apb_rd && paddr == RSF_OFF_DATA_A;
      buf_rd[1] = apb_rd && paddr == RSF_OFF_DATA_B;
   end

   for (genvar c = 0; c < 2; c++)
   begin : g_buf
      rsf_entry_t we;
      always_comb
      begin
         we.data = ev[c].data;
         we.crc_err = !ev[c].crc_ok; // RULE13
         we.residue = ev[c].residue;
      end
      rsf_rx_buf #(.DEPTH(RSF_BUF_DEPTH)) u_buf (
         .core_clk_i(core_clk_i),
         .rst_n_i(rst_n_i),
         .wr_i(ev[c].valid),
         .wr_data_i(we),
         .rd_i(buf_rd[c]),
         .rd_data_o(rd_ent[c]),
         .full_o(buf_full[c]),
         .empty_o(buf_empty[c])
      );
   end

   always_comb
   begin
      rsf_mode_t m;
      logic pe;
      logic ovr_ev;
      logic sp;
      m = RSF_ASYNC;
      pe = 1'b0;
      ovr_ev = 1'b0;
      sp = 1'b0;
      s_d = s_q;
      s_d.rsp = rsp_d;
      // Priority pin is asynchronous: three stages, change when 2 and 3 agree
      s_d.prio_sync = {s_q.prio_sync[1:0], prio_in_i};
      if (s_q.prio_sync[2] == s_q.prio_sync[1])
         s_d.prio = s_q.prio_sync[2];
      for (int c = 0; c < 2; c++)
      begin
         m = mode_of(s_q.cfg[c]);
         sp = 1'b0;
         if (err_rst[c])
            s_d.fl[c] = '0; // RULE21 RULE11
         if (ev[c].valid)
         begin
            ovr_ev = buf_full[c] && !buf_rd[c];
            if (ovr_ev)
            begin
               s_d.fl[c].ovr = 1'b1; // RULE15
               sp = 1'b1; // RULE15
            end
            pe = s_q.cfg[c][RSF_CFG_PAREN]
               && par_bad(ev[c].data, s_q.cfg[c][RSF_CFG_PAREVEN]);
            if (pe)
            begin
               s_d.fl[c].par = 1'b1; // RULE16
               if (s_q.cfg[c][RSF_CFG_IM_HI:RSF_CFG_IM_LO]
                  == RSF_IM_PAR_SPECIAL)
                  sp = 1'b1; // RULE17
            end
            unique case (m)
               RSF_ASYNC:
               begin
                  // Stop bit position comes from the receiver's char length
                  s_d.fl[c].crcfe = !ev[c].stop_bit; // RULE8 RULE9 RULE10
                  if (!ev[c].stop_bit)
                     sp = 1'b1; // RULE8
               end
               RSF_SYNC:
                  s_d.fl[c].crcfe = !ev[c].crc_ok; // RULE11 RULE12 RULE13
               RSF_HDLC:
               begin
                  // Freeze CRC and residue while EOF stands
                  if (!s_q.fl[c].eof || err_rst[c])
                  begin
                     s_d.fl[c].crcfe = !ev[c].crc_ok; // RULE7 RULE11
                     s_d.fl[c].res = ev[c].closing_flag
                        ? ev[c].residue : RSF_RES_NONE; // RULE18 RULE19
                  end
                  if (ev[c].closing_flag)
                  begin
                     s_d.fl[c].eof = 1'b1; // RULE6
                     sp = 1'b1; // RULE6
                  end
               end
               default: ;
            endcase
         end
         s_d.irq[c] = sp;
      end
      // APB: writes take effect at access, one-cycle answer
      if (apb_wr)
      begin
         if (paddr == RSF_OFF_CFG_A)
            s_d.cfg[0] = pwdata[7:0];
         if (paddr == RSF_OFF_CFG_B)
            s_d.cfg[1] = pwdata[7:0];
         if (paddr == RSF_OFF_BUS)
            s_d.dma = pwdata[1:0];
      end
   end

   function automatic logic [7:0] cond_byte(input rsf_flags_t f,
                                           input logic sent,
                                           input logic async_m);
      cond_byte = {f.eof, f.crcfe, f.ovr, f.par, f.res,
                   async_m ? sent : 1'b1}; // RULE5 RULE20
   endfunction

   logic ipend;
   always_comb
   begin
      ipend = |in_service_i; // RULE2
      if (s_q.dma == RSF_DMA_NONE && s_q.prio)
         ipend = 1'b0; // RULE3
   end

   always_comb
   begin
      rsf_apb_rsp_t r;
      r.prdata = 32'h0;
      r.pslverr = 1'b0;
      unique case (paddr)
         RSF_OFF_MAIN_A:
            r.prdata[7:0] = {6'h0, ipend, !buf_empty[0]}; // RULE1 RULE4
         RSF_OFF_MAIN_B:
            r.prdata[7:0] = {6'h0, 1'b0, !buf_empty[1]}; // RULE1 RULE4
         RSF_OFF_COND_A:
            r.prdata[7:0] = cond_byte(s_q.fl[0], tx_empty_i[0],
                                      mode_of(s_q.cfg[0]) == RSF_ASYNC);
         RSF_OFF_COND_B:
            r.prdata[7:0] = cond_byte(s_q.fl[1], tx_empty_i[1],
                                      mode_of(s_q.cfg[1]) == RSF_ASYNC);
         RSF_OFF_CMD: r.prdata = 32'h0;
         RSF_OFF_CFG_A: r.prdata[7:0] = s_q.cfg[0];
         RSF_OFF_CFG_B: r.prdata[7:0] = s_q.cfg[1];
         RSF_OFF_BUS: r.prdata[1:0] = s_q.dma;
         RSF_OFF_DATA_A: r.prdata[7:0] = 8'h0;
         RSF_OFF_DATA_B: r.prdata[7:0] = 8'h0;
         default: r.pslverr = 1'b1;
      endcase
      rsp_d = r;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_q <= '0;
         s_q.cfg <= {RSF_CFG_RST, RSF_CFG_RST};
         s_q.dma <= RSF_BUS_RST;
         s_q.prio_sync <= 3'h0;
      end
      else
         s_q <= s_d;
   end

   // Registered data for every register, sampled in setup cycle
   assign pready = psel && penable;
   assign prdata = s_q.rsp.prdata;
   assign pslverr = psel && penable && s_q.rsp.pslverr;
   assign special_irq_o = s_q.irq;

   property p_eof_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (s_q.fl[0].eof && !err_rst[0]) |=> s_q.fl[0].eof;
   endproperty
   a_eof_hold: assert property (p_eof_hold) else $error("eof lost"); // RULE6

   property p_res_stable;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (s_q.fl[0].eof && !err_rst[0]) |=> $stable(s_q.fl[0].res)
         && $stable(s_q.fl[0].crcfe);
   endproperty
   a_res_stable: assert property (p_res_stable) else $error("res moved"); // RULE7

   property p_clear_all;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (err_rst[0] && !ev[0].valid) |=> s_q.fl[0] == '0;
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("no clear"); // RULE21

   property p_ovr;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ev[0].valid && buf_full[0] && !buf_rd[0]) |=> s_q.fl[0].ovr && s_q.irq[0];
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun missed"); // RULE15

   property p_frame;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ev[0].valid && !ev[0].stop_bit && mode_of(s_q.cfg[0]) == RSF_ASYNC)
         |=> s_q.fl[0].crcfe && s_q.irq[0];
   endproperty
   a_frame: assert property (p_frame) else $error("frame err missed"); // RULE8

   property p_sync_noirq;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ev[0].valid && mode_of(s_q.cfg[0]) == RSF_SYNC && !buf_full[0]
         && !s_q.cfg[0][RSF_CFG_PAREN]) |=> !s_q.irq[0];
   endproperty
   a_sync_noirq: assert property (p_sync_noirq) else $error("crc irq"); // RULE12

   property p_chb_zero;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (psel && paddr == RSF_OFF_MAIN_B) |=> prdata[RSF_MS_IPEND] == 1'b0;
   endproperty
   a_chb_zero: assert property (p_chb_zero) else $error("B pending"); // RULE1

   property p_prio;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (s_q.dma == RSF_DMA_NONE && s_q.prio) |-> !ipend;
   endproperty
   a_prio: assert property (p_prio) else $error("pending with prio"); // RULE3

   sequence s_rd_main_a;
      psel && !penable && paddr == RSF_OFF_MAIN_A;
   endsequence

   property p_rxav;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_rd_main_a |=> prdata[RSF_MS_RXAV] == !$past(buf_empty[0]);
   endproperty
   a_rxav: assert property (p_rxav) else $error("rx avail wrong"); // RULE4

   property p_ipend;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_rd_main_a ##0 (|in_service_i
         && !(s_q.dma == RSF_DMA_NONE && s_q.prio)) |=> prdata[RSF_MS_IPEND];
   endproperty
   a_ipend: assert property (p_ipend) else $error("pending lost"); // RULE2

   property p_par;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ev[0].valid && s_q.cfg[0][RSF_CFG_PAREN]
         && par_bad(ev[0].data, s_q.cfg[0][RSF_CFG_PAREVEN]))
         |=> s_q.fl[0].par;
   endproperty
   a_par: assert property (p_par) else $error("parity missed"); // RULE16

   sequence s_close_hdlc;
      ev[0].valid && ev[0].closing_flag
         && mode_of(s_q.cfg[0]) == RSF_HDLC;
   endsequence

   property p_eof_set;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_close_hdlc |=> s_q.fl[0].eof && s_q.irq[0];
   endproperty
   a_eof_set: assert property (p_eof_set) else $error("eof missed"); // RULE6
endmodule // rsf_status

//--- rsf_host.sv
// Host model: APB master that reads and clears the status registers
`timescale 1ns/100ps
module rsf_host
(
   input wire logic core_clk_i,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // Request held until pready is seen at an edge; only the bench
   // watchdog ends a wait on a dead slave
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge core_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk_i);
      penable <= 1'b1;
      @(posedge core_clk_i);
      while (pready !== 1'b1)
         @(posedge core_clk_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale write data is not left on the bus after release
      pwdata <= ~wd;
   endtask
endmodule // rsf_host

//--- rsf_status_tb.sv
// Self-checking bench for the receive status flag block
`timescale 1ns/100ps
module rsf_status_tb;
   import rsf_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   rsf_rx_ev_t ev_a = '0;
   rsf_rx_ev_t ev_b = '0;
   logic [1:0] in_service = 2'b00;
   logic prio = 1'b0;
   logic [1:0] tx_empty = 2'b01;
   logic [1:0] irq;
   int bad_count = 0;
   int check_count = 0;

   always #50 core_clk_i = ~core_clk_i;

   rsf_host host (.core_clk_i(core_clk_i), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   rsf_status uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_ev_a_i(ev_a), .rx_ev_b_i(ev_b),
      .in_service_i(in_service), .prio_in_i(prio),
      .tx_empty_i(tx_empty), .special_irq_o(irq));

   task automatic summarize();
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      host.xfer(1'b0, a, 32'h0, d, e);
      chk(d, exp);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      host.xfer(1'b1, a, d, r, e);
   endtask

   task automatic pop(input int n);
      repeat (n) rd(RSF_OFF_DATA_A, 32'h0);
   endtask

   // One received character; the special pulse is looked for over a short
   // window so the exact pulse cycle does not matter
   task automatic ev(input logic [7:0] d, input logic stop, input logic ok,
      input logic flag, input logic [2:0] res, input logic exp_irq);
      logic seen;
      seen = 1'b0;
      @(posedge core_clk_i);
      ev_a <= '{1'b1, d, stop, ok, flag, res};
      @(posedge core_clk_i);
      ev_a.valid <= 1'b0;
      repeat (3)
      begin
         @(posedge core_clk_i);
         seen = seen | irq[0];
      end
      chk({31'h0, seen}, {31'h0, exp_irq});
   endtask

   task automatic t_reset();
      logic [31:0] d;
      logic e;
      rd(RSF_OFF_MAIN_A, 32'h0);
      rd(RSF_OFF_COND_A, 32'h1);
      rd(RSF_OFF_COND_B, 32'h0);
      host.xfer(1'b0, 12'h030, 32'h0, d, e);
      chk({31'h0, e}, 32'h1);
      chk(d, 32'h0);
   endtask

   task automatic t_pend();
      wr(RSF_OFF_BUS, {30'h0, RSF_DMA_NONE});
      in_service <= 2'b10;
      rd(RSF_OFF_MAIN_A, 32'h2);
      rd(RSF_OFF_MAIN_B, 32'h0);
      prio <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      rd(RSF_OFF_MAIN_A, 32'h0);
      prio <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      rd(RSF_OFF_MAIN_A, 32'h2);
      in_service <= 2'b00;
      rd(RSF_OFF_MAIN_A, 32'h0);
   endtask

   task automatic t_async();
      ev(8'h55, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_MAIN_A, 32'h1);
      ev(8'h55, 1'b0, 1'b1, 1'b0, RSF_RES_NONE, 1'b1);
      rd(RSF_OFF_COND_A, 32'h41);
      ev(8'h56, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_COND_A, 32'h1);
      pop(3);
      rd(RSF_OFF_MAIN_A, 32'h0);
   endtask

   task automatic t_ovr();
      repeat (3) ev(8'h11, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      ev(8'h12, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b1);
      ev(8'h13, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b1);
      rd(RSF_OFF_COND_A, 32'h21);
      wr(RSF_OFF_CMD, 32'h1);
      rd(RSF_OFF_COND_A, 32'h1);
      pop(3);
      rd(RSF_OFF_MAIN_A, 32'h0);
   endtask

   task automatic t_par();
      wr(RSF_OFF_CFG_A, 32'h24);
      ev(8'h01, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      ev(8'h03, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b1);
      ev(8'h01, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_COND_A, 32'h11);
      wr(RSF_OFF_CMD, 32'h1);
      pop(3);
      wr(RSF_OFF_CFG_A, 32'h04);
      ev(8'h03, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_COND_A, 32'h11);
      wr(RSF_OFF_CMD, 32'h1);
      pop(1);
      wr(RSF_OFF_CFG_A, 32'h0c);
      ev(8'h03, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_COND_A, 32'h1);
      ev(8'h01, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_COND_A, 32'h11);
      wr(RSF_OFF_CMD, 32'h1);
      pop(2);
   endtask

   task automatic t_hdlc();
      logic [2:0] codes [6] = '{3'h4, 3'h2, 3'h6, 3'h1, 3'h5, 3'h3};
      wr(RSF_OFF_CFG_A, 32'h2);
      ev(8'h11, 1'b1, 1'b0, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_COND_A, 32'h41);
      wr(RSF_OFF_CMD, 32'h1);
      pop(1);
      foreach (codes[i])
      begin
         ev(8'h22, 1'b1, 1'b1, 1'b1, codes[i], 1'b1);
         rd(RSF_OFF_COND_A, {24'h0, 4'h8, codes[i], 1'b1});
         ev(8'h33, 1'b1, 1'b0, 1'b0, RSF_RES_NONE, 1'b0);
         rd(RSF_OFF_COND_A, {24'h0, 4'h8, codes[i], 1'b1});
         wr(RSF_OFF_CMD, 32'h1);
         rd(RSF_OFF_COND_A, 32'h1);
         pop(2);
      end
   endtask

   // Sync mode CRC flag per character, then a mid-run reset clears it
   task automatic t_sync();
      wr(RSF_OFF_CFG_A, 32'h1);
      ev(8'h21, 1'b1, 1'b0, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_COND_A, 32'h41);
      ev(8'h22, 1'b1, 1'b1, 1'b0, RSF_RES_NONE, 1'b0);
      rd(RSF_OFF_COND_A, 32'h1);
      ev(8'h23, 1'b1, 1'b0, 1'b0, RSF_RES_NONE, 1'b0);
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rd(RSF_OFF_COND_A, 32'h1);
      rd(RSF_OFF_MAIN_A, 32'h0);
   endtask

   // Channel B framing error, its own clear and its own buffer
   task automatic t_chan_b();
      @(posedge core_clk_i);
      ev_b <= '{1'b1, 8'h5a, 1'b0, 1'b1, 1'b0, RSF_RES_NONE};
      @(posedge core_clk_i);
      ev_b.valid <= 1'b0;
      @(posedge core_clk_i);
      chk({31'h0, irq[1]}, 32'h1);
      rd(RSF_OFF_COND_B, 32'h40);
      rd(RSF_OFF_MAIN_B, 32'h1);
      wr(RSF_OFF_CMD, 32'h2);
      rd(RSF_OFF_COND_B, 32'h0);
      rd(RSF_OFF_DATA_B, 32'h0);
      rd(RSF_OFF_MAIN_B, 32'h0);
   endtask

   initial
   begin
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_pend();
      t_async();
      t_ovr();
      t_par();
      t_sync();
      t_hdlc();
      t_chan_b();
      summarize();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      bad_count++;
      summarize();
   end
endmodule // rsf_status_tb
